/* File: logic/rscd_pkg.sv */
// Opcodes, command kinds and carriers of the radio serial command decoder
package rscd_pkg;
   localparam logic [2:0] OPG_REG_RD = 3'h0;
   localparam logic [2:0] OPG_REG_WR = 3'h1;
   localparam logic [4:0] OPG_ACK_WR = 5'h15;
   localparam logic [7:0] OP_RX_RD = 8'h61;
   localparam logic [7:0] OP_TX_WR = 8'hA0;
   localparam logic [7:0] OP_FLUSH_TX = 8'hE1;
   localparam logic [7:0] OP_FLUSH_RX = 8'hE2;
   localparam logic [7:0] OP_TX_REPEAT = 8'hE3;
   localparam logic [7:0] OP_RX_WIDTH = 8'h60;
   localparam logic [7:0] OP_NOACK_WR = 8'hB0;
   localparam logic [7:0] OP_NOP = 8'hFF;
   localparam logic [2:0] PIPE_LAST = 3'h5;
   localparam int PAYLOAD_MAX = 32;
   localparam int REG_BYTES_MAX = 5;
   localparam int STAT_PIPE_LSB = 1;
   localparam int STAT_PIPE_W = 3;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [2:0] PIPE_RST = 3'h0;
   localparam int FEAT_NOACK = 0;
   localparam int FEAT_ACK = 1;
   localparam int FEAT_WIDTH = 2;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [5:0] BYTE_SAT = 6'h3F;

   typedef enum logic [3:0] {
      K_NONE = 4'h0, K_REG_RD = 4'h1, K_REG_WR = 4'h2, K_RX_RD = 4'h3,
      K_TX_WR = 4'h4, K_FLUSH_TX = 4'h5, K_FLUSH_RX = 4'h6, K_REPEAT = 4'h7,
      K_WIDTH = 4'h8, K_ACK_WR = 4'h9, K_NOACK_WR = 4'hA, K_NOP = 4'hB
   } rscd_kind_t;

   typedef enum logic [1:0] {
      SRC_NONE = 2'h0, SRC_REG = 2'h1, SRC_RXPAY = 2'h2, SRC_WIDTH = 2'h3
   } rscd_src_t;

   typedef struct packed {
      rscd_src_t src;
      logic [4:0] index;
      logic [5:0] byte_no;
   } rscd_rd_sel_t;

   typedef struct packed {
      logic is_cmd;
      logic [5:0] byte_no;
      logic [7:0] data;
   } rscd_link_ev_t;

   typedef struct packed {
      rscd_kind_t kind;
      logic [4:0] index;
      logic [5:0] byte_no;
      logic [7:0] data;
   } rscd_wbyte_t;

   typedef struct packed {
      rscd_kind_t kind;
      logic [2:0] pipe;
      logic [5:0] length;
   } rscd_commit_t;

   function automatic rscd_kind_t rscd_decode(input logic [7:0] op, input logic [2:0] feat);
      rscd_kind_t k;
      k = K_NONE;
      if (op[7:5] == OPG_REG_RD) k = K_REG_RD;
      else if (op[7:5] == OPG_REG_WR) k = K_REG_WR;
      else if (op[7:3] == OPG_ACK_WR) begin
         if (feat[FEAT_ACK] && op[2:0] <= PIPE_LAST) k = K_ACK_WR;
      end else begin
         case (op)
            OP_RX_RD: k = K_RX_RD;
            OP_TX_WR: k = K_TX_WR;
            OP_FLUSH_TX: k = K_FLUSH_TX;
            OP_FLUSH_RX: k = K_FLUSH_RX;
            OP_TX_REPEAT: k = K_REPEAT;
            OP_RX_WIDTH: k = feat[FEAT_WIDTH] ? K_WIDTH : K_NONE;
            OP_NOACK_WR: k = feat[FEAT_NOACK] ? K_NOACK_WR : K_NONE;
            OP_NOP: k = K_NOP;
            default: k = K_NONE;
         endcase
      end
      return k;
   endfunction
endpackage

/* File: logic/rscd_top.sv */
// Serial command decoder: link-side shifter and system-side command executor
`timescale 1ns/1ns
`default_nettype none

module rscd_top
   import rscd_pkg::*;
#(
   parameter int PAY_MAX = PAYLOAD_MAX,
   parameter int REG_MAX = REG_BYTES_MAX
) (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic SCK,
   input wire logic SEL_N,
   input wire logic MOSI,
   output logic MISO,
   output logic MISO_OE,
   input wire logic [7:0] STATUS_IN,
   input wire logic IRQ_N,
   input wire logic [2:0] FEATURE_EN,
   input wire logic TX_FULL,
   output rscd_rd_sel_t RD_SEL,
   input wire logic [7:0] RD_BYTE,
   output logic REG_WR_VLD,
   output rscd_wbyte_t REG_WR,
   output logic TX_WR_VLD,
   output rscd_wbyte_t TX_WR,
   output logic TX_COMMIT_VLD,
   output rscd_commit_t TX_COMMIT,
   output logic TX_FLUSH,
   output logic RX_FLUSH,
   output logic RX_POP,
   output logic TX_REPEAT
);

   if (PAY_MAX < 1 || PAY_MAX > 63) begin : g_bad_pay
      $error("PAY_MAX must lie in 1..63");
   end
   if (REG_MAX < 1 || REG_MAX > 8) begin : g_bad_reg
      $error("REG_MAX must lie in 1..8");
   end

   localparam logic [5:0] PAY_LIM = 6'(PAY_MAX);
   localparam logic [5:0] REG_LIM = 6'(REG_MAX);

   // System clock: reset for the link side
   logic link_rst_q;
   logic [7:0] status_q;

   always_ff @(posedge MCLK) begin
      link_rst_q <= SRST;
   end

   // Link side, clocked by SCK
   // Select high clears the frame state; the link clock may stop between frames
   logic frame_rst;
   assign frame_rst = SEL_N | link_rst_q;

   logic [2:0] bit_q;
   logic [6:0] sh_q;
   logic cmd_vld_q;
   logic [5:0] byte_q;
   rscd_kind_t lk_kind;
   logic [7:0] in_byte;
   rscd_src_t lk_src;

   assign in_byte = {sh_q, MOSI};
   // Feature bits are configuration, steady while a frame runs
   assign lk_kind = rscd_decode(in_byte, FEATURE_EN);

   always_comb begin
      unique case (lk_kind)
         K_REG_RD: lk_src = SRC_REG;
         K_RX_RD: lk_src = SRC_RXPAY;
         K_WIDTH: lk_src = SRC_WIDTH;
         default: lk_src = SRC_NONE;
      endcase
   end

   // Bits taken on rising edges, MSBit first
   always_ff @(posedge SCK or posedge frame_rst) begin
      if (frame_rst) begin
         bit_q <= 3'h0;
         sh_q <= 7'h00;
         cmd_vld_q <= 1'b0;
         byte_q <= 6'h00;
         RD_SEL <= '0;
      end else begin
         bit_q <= bit_q + 3'h1;
         sh_q <= in_byte[6:0];
         if (bit_q == BIT_LAST) begin
            if (!cmd_vld_q) begin
               cmd_vld_q <= 1'b1;
               RD_SEL.src <= lk_src;
               RD_SEL.index <= in_byte[4:0];
               RD_SEL.byte_no <= 6'h00;
            end else if (byte_q != BYTE_SAT) begin
               byte_q <= byte_q + 6'h01;
               RD_SEL.byte_no <= byte_q + 6'h01;
            end
         end
      end
   end

   // Each finished byte is handed over as a word with a toggle; the word
   // stands for a whole byte time, far longer than the two-flop crossing
   rscd_link_ev_t ev_q;
   logic ev_tgl_q;

   always_ff @(posedge SCK or posedge link_rst_q) begin
      if (link_rst_q) begin
         ev_q <= '0;
         ev_tgl_q <= 1'b0;
      end else if (bit_q == BIT_LAST) begin
         ev_q.is_cmd <= !cmd_vld_q;
         ev_q.byte_no <= byte_q;
         ev_q.data <= in_byte;
         ev_tgl_q <= !ev_tgl_q;
      end
   end

   // MISO changes on falling edges
   logic first_q;
   logic out_q;
   logic [6:0] osh_q;
   logic [7:0] rd_gated;

   assign rd_gated = (RD_SEL.src == SRC_NONE) ? 8'h00 : RD_BYTE;

   always_ff @(negedge SCK or posedge frame_rst) begin
      if (frame_rst) begin
         first_q <= 1'b1;
         out_q <= 1'b0;
         osh_q <= 7'h00;
      end else begin
         first_q <= 1'b0;
         if (!cmd_vld_q) begin
            out_q <= status_q[3'h7 - bit_q];
         end else if (bit_q == 3'h0) begin
            out_q <= rd_gated[7];
            osh_q <= rd_gated[6:0];
         end else begin
            out_q <= osh_q[6];
            osh_q <= {osh_q[5:0], 1'b0};
         end
      end
   end

   // First status bit must stand before any clock edge, so it bypasses out_q
   assign MISO = first_q ? status_q[7] : out_q;
   assign MISO_OE = !frame_rst;

   // System side, clocked by MCLK
   logic sel_s1_q;
   logic sel_s2_q;
   logic sel_s3_q;
   logic end_q;
   logic ev_s1_q;
   logic ev_s2_q;
   logic ev_seen_q;
   logic ev_new;

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         sel_s1_q <= 1'b1;
         sel_s2_q <= 1'b1;
         sel_s3_q <= 1'b1;
         end_q <= 1'b0;
      end else begin
         sel_s1_q <= SEL_N;
         sel_s2_q <= sel_s1_q;
         sel_s3_q <= sel_s2_q;
         // One cycle late so the last byte's word is handled first
         end_q <= sel_s2_q & !sel_s3_q;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ev_s1_q <= 1'b0;
         ev_s2_q <= 1'b0;
         ev_seen_q <= 1'b0;
      end else begin
         ev_s1_q <= ev_tgl_q;
         ev_s2_q <= ev_s1_q;
         ev_seen_q <= ev_s2_q;
      end
   end

   assign ev_new = ev_s2_q ^ ev_seen_q;

   // Status copy frozen while select is low; pipe field moves only on an
   // interrupt falling edge, so a read at that moment may catch either value
   logic irq_prev_q;
   logic [2:0] pipe_q;
   logic [7:0] status_d;

   always_comb begin
      status_d = STATUS_IN;
      status_d[STAT_PIPE_LSB +: STAT_PIPE_W] = pipe_q;
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         irq_prev_q <= 1'b1;
         pipe_q <= PIPE_RST;
         status_q <= STATUS_RST;
      end else begin
         irq_prev_q <= IRQ_N;
         if (irq_prev_q && !IRQ_N) begin
            pipe_q <= STATUS_IN[STAT_PIPE_LSB +: STAT_PIPE_W];
         end
         if (sel_s2_q) begin
            status_q <= status_d;
         end
      end
   end

   // Command execution
   rscd_kind_t ev_kind;
   rscd_kind_t kind_q;
   logic [4:0] idx_q;
   logic [5:0] len_q;
   logic drop_q;
   logic rx_rd_q;
   logic pay_kind;

   assign ev_kind = rscd_decode(ev_q.data, FEATURE_EN);
   assign pay_kind = (kind_q == K_TX_WR) || (kind_q == K_ACK_WR)
                     || (kind_q == K_NOACK_WR);

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         kind_q <= K_NONE;
         idx_q <= 5'h00;
         len_q <= 6'h00;
         drop_q <= 1'b0;
         rx_rd_q <= 1'b0;
      end else if (ev_new && ev_q.is_cmd) begin
         kind_q <= ev_kind;
         idx_q <= ev_q.data[4:0];
         len_q <= 6'h00;
         drop_q <= 1'b0;
         rx_rd_q <= 1'b0;
      end else if (ev_new) begin
         if (kind_q == K_RX_RD) begin
            rx_rd_q <= 1'b1;
         end
         if (pay_kind && ev_q.byte_no == 6'h00 && TX_FULL) begin
            drop_q <= 1'b1;
         end
         if (pay_kind && ev_q.byte_no < PAY_LIM) begin
            len_q <= ev_q.byte_no + 6'h01;
         end
      end else if (end_q) begin
         kind_q <= K_NONE;
         // An empty frame must not pop the receive payload a second time
         rx_rd_q <= 1'b0;
      end
   end

   // Byte writes towards the register file and the transmit FIFO
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         REG_WR_VLD <= 1'b0;
         REG_WR <= '0;
         TX_WR_VLD <= 1'b0;
         TX_WR <= '0;
      end else begin
         REG_WR_VLD <= 1'b0;
         TX_WR_VLD <= 1'b0;
         if (ev_new && !ev_q.is_cmd) begin
            if (kind_q == K_REG_WR && ev_q.byte_no < REG_LIM) begin
               // Each byte lands alone, so a short write leaves upper bytes
               REG_WR_VLD <= 1'b1;
               REG_WR.kind <= kind_q;
               REG_WR.index <= idx_q;
               REG_WR.byte_no <= ev_q.byte_no;
               REG_WR.data <= ev_q.data;
            end
            if (pay_kind && ev_q.byte_no < PAY_LIM
                && !(drop_q || (ev_q.byte_no == 6'h00 && TX_FULL))) begin
               TX_WR_VLD <= 1'b1;
               TX_WR.kind <= kind_q;
               TX_WR.index <= idx_q;
               TX_WR.byte_no <= ev_q.byte_no;
               TX_WR.data <= ev_q.data;
            end
         end
      end
   end

   // Frame-end commits and zero-byte commands
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         TX_COMMIT_VLD <= 1'b0;
         TX_COMMIT <= '0;
         TX_FLUSH <= 1'b0;
         RX_FLUSH <= 1'b0;
         RX_POP <= 1'b0;
      end else begin
         TX_COMMIT_VLD <= 1'b0;
         TX_FLUSH <= 1'b0;
         RX_FLUSH <= 1'b0;
         RX_POP <= 1'b0;
         if (ev_new && ev_q.is_cmd) begin
            TX_FLUSH <= (ev_kind == K_FLUSH_TX);
            RX_FLUSH <= (ev_kind == K_FLUSH_RX);
         end
         if (end_q) begin
            RX_POP <= rx_rd_q;
            if (pay_kind && !drop_q && len_q != 6'h00) begin
               TX_COMMIT_VLD <= 1'b1;
               TX_COMMIT.kind <= kind_q;
               TX_COMMIT.pipe <= idx_q[2:0];
               TX_COMMIT.length <= len_q;
            end
         end
      end
   end

   // Payload repeat mode
   logic rep_set;
   logic rep_clr;

   assign rep_set = ev_new && ev_q.is_cmd && ev_kind == K_REPEAT;
   assign rep_clr = (ev_new && ev_q.is_cmd && ev_kind == K_FLUSH_TX)
                    || (end_q && kind_q == K_TX_WR && !drop_q && len_q != 6'h00);

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         TX_REPEAT <= 1'b0;
      end else if (rep_set) begin
         TX_REPEAT <= 1'b1;
      end else if (rep_clr) begin
         TX_REPEAT <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* File: bench/rscd_host.sv */
// Host-side serial link master model
`timescale 1ns/1ns
`default_nettype none
module rscd_host (
   output logic SCK,
   output logic SEL_N,
   output logic MOSI,
   input wire logic MISO,
   input wire logic MISO_OE
);
   initial begin
      SCK = 1'b0;
      SEL_N = 1'b1;
      MOSI = 1'b0;
   end
   task automatic open_f();
      SEL_N = 1'b0;
      #32;
   endtask
   // Undriven line reads as z so a missing enable never matches
   task automatic xfer(input logic [7:0] t, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         MOSI = t[i];
         #32;
         r[i] = MISO_OE ? MISO : 1'bz;
         SCK = 1'b1;
         #32;
         SCK = 1'b0;
      end
   endtask
   task automatic close_f();
      #32;
      SEL_N = 1'b1;
      MOSI = ~MOSI;
      #100;
   endtask
endmodule
`default_nettype wire

/* File: bench/rscd_chk.sv */
// Port checker of the command decoder
`timescale 1ns/1ns
`default_nettype none
module rscd_chk
   import rscd_pkg::*;
#(
   parameter int PAY_MAX = PAYLOAD_MAX,
   parameter int REG_MAX = REG_BYTES_MAX
) (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic SEL_N,
   input wire logic MISO_OE,
   input wire logic [2:0] FEATURE_EN,
   input wire logic REG_WR_VLD,
   input wire rscd_wbyte_t REG_WR,
   input wire logic TX_WR_VLD,
   input wire rscd_wbyte_t TX_WR,
   input wire logic TX_COMMIT_VLD,
   input wire rscd_commit_t TX_COMMIT,
   input wire logic TX_FLUSH,
   input wire logic RX_FLUSH,
   input wire logic RX_POP,
   input wire logic TX_REPEAT
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   sequence s_wr_quiet;
      !TX_WR_VLD [*8];
   endsequence
   sequence s_flush_end;
      !TX_REPEAT ##1 !TX_FLUSH;
   endsequence
   chk_oe_deselect: assert property (SEL_N |-> !MISO_OE)
      else $error("output driven while deselected");
   chk_flush_tx: assert property (TX_FLUSH |-> s_flush_end)
      else $error("tx flush too long or repeat kept");
   chk_flush_rx: assert property (RX_FLUSH |=> !RX_FLUSH)
      else $error("rx flush too long");
   chk_pop_frame: assert property (RX_POP |-> SEL_N ##1 !RX_POP)
      else $error("rx pop inside frame");
   chk_reg_byte: assert property (REG_WR_VLD |->
      REG_WR.kind == K_REG_WR && REG_WR.byte_no < REG_MAX)
      else $error("bad register byte");
   chk_pay_byte: assert property (TX_WR_VLD |->
      TX_WR.byte_no < PAY_MAX ##1 s_wr_quiet)
      else $error("bad payload byte");
   chk_ack_gate: assert property (TX_WR_VLD && TX_WR.kind == K_ACK_WR |->
      FEATURE_EN[FEAT_ACK] && TX_WR.index[2:0] <= PIPE_LAST)
      else $error("ack payload accepted wrongly");
   chk_noack_gate: assert property (TX_WR_VLD && TX_WR.kind == K_NOACK_WR |->
      FEATURE_EN[FEAT_NOACK])
      else $error("no-ack payload accepted wrongly");
   chk_commit_len: assert property (TX_COMMIT_VLD |->
      SEL_N && TX_COMMIT.length > 0 && TX_COMMIT.length <= PAY_MAX)
      else $error("bad commit");
endmodule
bind rscd_top rscd_chk #(.PAY_MAX(PAY_MAX), .REG_MAX(REG_MAX)) rscd_chk_inst (.MCLK, .SRST,
   .SEL_N, .MISO_OE, .FEATURE_EN, .REG_WR_VLD, .REG_WR, .TX_WR_VLD, .TX_WR, .TX_COMMIT_VLD,
   .TX_COMMIT, .TX_FLUSH, .RX_FLUSH, .RX_POP, .TX_REPEAT);
`default_nettype wire

/* File: bench/radio_spi_command_decoder_bench.sv */
// Self-checking bench of the serial command decoder
`timescale 1ns/1ns
`default_nettype none
module radio_spi_command_decoder_bench;
   import rscd_pkg::*;
   logic mclk, srst, sck, sel_n, mosi, miso, miso_oe, irq_n, tx_full;
   logic reg_wr_vld, tx_wr_vld, tx_commit_vld, tx_flush, rx_flush, rx_pop, tx_repeat;
   logic [7:0] status_in, rd_byte, st, s1, db[40], rb[40];
   logic [2:0] feature_en;
   logic [31:0] rng;
   rscd_rd_sel_t rd_sel;
   rscd_wbyte_t reg_wr, tx_wr, wq[$];
   rscd_commit_t tx_commit, cq[$];
   int n_fail, check_count, cyc, n_txf, n_rxf, n_pop, n, p;
   rscd_top rscd_top_inst (.MCLK(mclk), .SRST(srst), .SCK(sck), .SEL_N(sel_n), .MOSI(mosi),
      .MISO(miso), .MISO_OE(miso_oe), .STATUS_IN(status_in), .IRQ_N(irq_n),
      .FEATURE_EN(feature_en), .TX_FULL(tx_full), .RD_SEL(rd_sel), .RD_BYTE(rd_byte),
      .REG_WR_VLD(reg_wr_vld), .REG_WR(reg_wr), .TX_WR_VLD(tx_wr_vld), .TX_WR(tx_wr),
      .TX_COMMIT_VLD(tx_commit_vld), .TX_COMMIT(tx_commit), .TX_FLUSH(tx_flush),
      .RX_FLUSH(rx_flush), .RX_POP(rx_pop), .TX_REPEAT(tx_repeat));
   rscd_host rscd_host_inst (.SCK(sck), .SEL_N(sel_n), .MOSI(mosi), .MISO(miso),
      .MISO_OE(miso_oe));
   function automatic logic [7:0] rd_val(rscd_src_t s, logic [4:0] i, int b);
      if (s == SRC_NONE) return 8'h00;
      return {(s == SRC_REG) ? i[2:0] : 3'h0, 5'(b)} ^ {6'h00, s};
   endfunction
   assign rd_byte = rd_val(rd_sel.src, rd_sel.index, int'(rd_sel.byte_no));
   function automatic logic [7:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One frame, then the write events it caused against the expected bytes
   task automatic wr(input logic [7:0] op, input int len, input rscd_kind_t k,
                     input logic [4:0] i, input int lim);
      int m;
      rscd_host_inst.open_f();
      rscd_host_inst.xfer(op, st);
      for (int b = 0; b < len; b++) begin
         db[b] = rnd();
         rscd_host_inst.xfer(db[b], rb[b]);
      end
      rscd_host_inst.close_f();
      repeat (20) @(negedge mclk);
      m = (len < lim) ? len : lim;
      check(wq.size(), m);
      for (int b = 0; b < m && b < wq.size(); b++) begin
         check(wq[b], {k, i, 6'(b), db[b]});
      end
      if (k inside {K_TX_WR, K_ACK_WR, K_NOACK_WR} && m > 0) begin
         check({cq.size(), cq[0].kind, cq[0].pipe, cq[0].length}, {32'h1, k, i[2:0], 6'(m)});
      end else begin
         check(cq.size(), 0);
      end
      wq.delete();
      cq.delete();
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (reg_wr_vld === 1'b1) wq.push_back(reg_wr);
      if (tx_wr_vld === 1'b1) wq.push_back(tx_wr);
      if (tx_commit_vld === 1'b1) cq.push_back(tx_commit);
      if (tx_flush === 1'b1) n_txf++;
      if (rx_flush === 1'b1) n_rxf++;
      if (rx_pop === 1'b1) n_pop++;
      if (cyc == 40000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      rng = 32'd26;
      srst = 1'b1;
      irq_n = 1'b1;
      tx_full = 1'b0;
      status_in = 8'h00;
      feature_en = 3'h7;
      repeat (6) @(negedge mclk);
      srst = 1'b0;
      repeat (5) @(negedge mclk);
      for (int t = 0; t < 4; t++) begin
         s1 = rnd();
         status_in = s1;
         irq_n = 1'b0;
         repeat (6) @(negedge mclk);
         irq_n = 1'b1;
         status_in = rnd();
         wr(OP_NOP, 0, K_NONE, 5'h00, 0);
         check(st, {status_in[7:4], s1[3:1], status_in[0]});
      end
      $display("test status done");
      for (int t = 0; t < 6; t++) begin
         p = rnd() % 32;
         n = (t == 0) ? 6 : 1 + rnd() % 5;
         wr({OPG_REG_WR, 5'(p)}, n, K_REG_WR, 5'(p), REG_BYTES_MAX);
         wr({OPG_REG_RD, 5'(p)}, 5, K_NONE, 5'h00, 0);
         for (int b = 0; b < 5; b++) check(rb[b], rd_val(SRC_REG, 5'(p), b));
      end
      $display("test registers done");
      for (int t = 0; t < 4; t++) begin
         n = (t == 0) ? 33 : (t == 1) ? 32 : 1 + rnd() % 32;
         wr(OP_TX_WR, n, K_TX_WR, 5'h00, PAYLOAD_MAX);
         wr(OP_NOACK_WR, n, K_NOACK_WR, OP_NOACK_WR[4:0], PAYLOAD_MAX);
      end
      for (int t = 0; t < 8; t++) begin
         wr({OPG_ACK_WR, 3'(t)}, 2, (t <= 5) ? K_ACK_WR : K_NONE,
            {OPG_ACK_WR[1:0], 3'(t)}, (t <= 5) ? 32 : 0);
      end
      tx_full = 1'b1;
      wr(OP_TX_WR, 4, K_TX_WR, 5'h00, 0);
      tx_full = 1'b0;
      $display("test payloads done");
      feature_en = 3'h0;
      wr({OPG_ACK_WR, 3'h0}, 2, K_NONE, 5'h00, 0);
      wr(OP_NOACK_WR, 2, K_NONE, 5'h00, 0);
      wr(OP_RX_WIDTH, 1, K_NONE, 5'h00, 0);
      check(rb[0], 8'h00);
      feature_en = 3'h7;
      wr(OP_RX_WIDTH, 1, K_NONE, 5'h00, 0);
      check(rb[0], rd_val(SRC_WIDTH, 5'h00, 0));
      wr(OP_RX_RD, 3, K_NONE, 5'h00, 0);
      for (int b = 0; b < 3; b++) check(rb[b], rd_val(SRC_RXPAY, 5'h00, b));
      check(n_pop, 1);
      $display("test reads done");
      wr(OP_TX_REPEAT, 0, K_NONE, 5'h00, 0);
      check(tx_repeat, 1'b1);
      wr(OP_NOACK_WR, 1, K_NOACK_WR, OP_NOACK_WR[4:0], 32);
      check(tx_repeat, 1'b1);
      wr(OP_FLUSH_TX, 0, K_NONE, 5'h00, 0);
      check({tx_repeat, n_txf}, {1'b0, 32'h1});
      wr(OP_TX_REPEAT, 0, K_NONE, 5'h00, 0);
      wr(OP_TX_WR, 1, K_TX_WR, 5'h00, 32);
      check(tx_repeat, 1'b0);
      wr(OP_FLUSH_RX, 0, K_NONE, 5'h00, 0);
      check(n_rxf, 1);
      $display("test flush and repeat done");
      end_of_test();
   end
endmodule
`default_nettype wire
